// ---- rtl/orr_pkg.sv ----
// constants and carriers for the or/return/rotate execution unit
// assumes one core clock and a synchronous active-low core reset
package orr_pkg;

  localparam logic [7:0] ACCUMULATOR_RST = 8'h00;
  localparam logic [7:0] INTR_CTL_RST = 8'h00;
  localparam logic [7:0] MEM_RST = 8'h00;
  localparam logic CARRY_RST = 1'b0;
  localparam logic ZERO_RST = 1'b0;
  localparam int MASTER_IE_BIT = 0;
  localparam int ROT_MSB = 7;

  typedef enum logic [3:0] {
    ORR_NOP = 4'h0,
    ORR_OR_IMM = 4'h1,
    ORR_OR_TO_MEMORY_OP = 4'h2,
    ORR_RET = 4'h3,
    ORR_RET_IMM = 4'h4,
    ORR_INTERRUPT_RETURN_OP = 4'h5,
    ORR_ROTATE_LEFT_OP = 4'h6,
    ORR_ROTATE_LEFT_TO_ACC_OP = 4'h7,
    ORR_ROTATE_LEFT_CARRY_OP = 4'h8,
    ORR_CALL = 4'h9,
    ORR_STORE_IMM = 4'hA,
    ORR_CLEAR_MASTER_IE = 4'hB
  } orr_op_t;

  typedef struct packed {
    orr_op_t op;
    logic [7:0] imm;
    logic [7:0] addr;
  } orr_instr_t;

endpackage : orr_pkg

// ---- rtl/orr_exec.sv ----
// single-cycle execution unit for or, return and left-rotate instructions
// assumes one instruction per instr_valid pulse, inputs synchronous to mclk
// How it works
// - or-immediate: accumulator becomes accumulator or immediate byte
// - or-to-memory: addressed byte becomes accumulator or byte, accumulator kept
// - subroutine return reloads program counter from top return stack entry
// - return-immediate pops program counter and loads accumulator with immediate
// - interrupt return pops program counter and sets master interrupt enable bit 0
// - rotate-left rotates addressed byte one place in place, bit 7 to bit 0
// - rotate-left-to-acc puts rotated byte in accumulator, memory unchanged
// - rotate-left-carry: nine-bit ring of byte and carry, written back to memory
module orr_exec #(
  parameter int PC_W = 11,
  parameter int STACK_DEPTH = 4,
  parameter int MEM_DEPTH = 64
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input orr_pkg::orr_instr_t instr,
  input wire logic [PC_W-1:0] call_target,
  output logic [7:0] accumulator,
  output logic carry,
  output logic zero,
  output logic [7:0] interrupt_control_reg,
  output logic master_interrupt_enable,
  output logic [PC_W-1:0] pc,
  output logic [$clog2(STACK_DEPTH)-1:0] stack_ptr,
  output logic [7:0] mem_rdata
);

  localparam int SP_W = $clog2(STACK_DEPTH);
  localparam int MA_W = $clog2(MEM_DEPTH);

  typedef struct packed {
    logic [7:0] accumulator;
    logic carry;
    logic zero;
    logic [7:0] intr_ctl;
    logic [PC_W-1:0] pc;
    logic [SP_W-1:0] sp;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
    logic [MEM_DEPTH-1:0][7:0] mem;
    logic [7:0] mem_rdata;
  } orr_state_t;

  orr_state_t s;
  orr_state_t next_s;
  logic [MA_W-1:0] ma;
  logic [7:0] mbyte;
  logic [SP_W-1:0] sp_dec;

  function automatic logic [7:0] rotl(input logic [7:0] b, input logic fill);
    rotl = {b[orr_pkg::ROT_MSB-1:0], fill};
  endfunction : rotl

  assign ma = instr.addr[MA_W-1:0];
  assign mbyte = s.mem[ma];
  assign sp_dec = s.sp - 1'b1;

  always_comb begin
    next_s = s;
    // read port shows the byte before this cycle's write
    next_s.mem_rdata = mbyte;
    if (instr_valid) begin
      next_s.pc = s.pc + 1'b1;
      case (instr.op)
        orr_pkg::ORR_OR_IMM: begin
          next_s.accumulator = s.accumulator | instr.imm;
        end
        orr_pkg::ORR_OR_TO_MEMORY_OP: begin
          next_s.mem[ma] = s.accumulator | mbyte;
        end
        orr_pkg::ORR_RET: begin
          next_s.pc = s.stack[sp_dec];
          next_s.sp = sp_dec;
        end
        orr_pkg::ORR_RET_IMM: begin
          next_s.pc = s.stack[sp_dec];
          next_s.sp = sp_dec;
          next_s.accumulator = instr.imm;
        end
        orr_pkg::ORR_INTERRUPT_RETURN_OP: begin
          next_s.pc = s.stack[sp_dec];
          next_s.sp = sp_dec;
          next_s.intr_ctl[orr_pkg::MASTER_IE_BIT] = 1'b1;
        end
        orr_pkg::ORR_ROTATE_LEFT_OP: begin
          next_s.mem[ma] = rotl(mbyte, mbyte[orr_pkg::ROT_MSB]);
        end
        orr_pkg::ORR_ROTATE_LEFT_TO_ACC_OP: begin
          next_s.accumulator = rotl(mbyte, mbyte[orr_pkg::ROT_MSB]);
        end
        orr_pkg::ORR_ROTATE_LEFT_CARRY_OP: begin
          next_s.mem[ma] = rotl(mbyte, s.carry);
          next_s.carry = mbyte[orr_pkg::ROT_MSB];
        end
        orr_pkg::ORR_CALL: begin
          // stack wraps when full: the oldest entry is overwritten
          next_s.stack[s.sp] = s.pc + 1'b1;
          next_s.sp = s.sp + 1'b1;
          next_s.pc = call_target;
        end
        orr_pkg::ORR_STORE_IMM: begin
          next_s.mem[ma] = instr.imm;
        end
        orr_pkg::ORR_CLEAR_MASTER_IE: begin
          next_s.intr_ctl[orr_pkg::MASTER_IE_BIT] = 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s.accumulator <= orr_pkg::ACCUMULATOR_RST;
      s.carry <= orr_pkg::CARRY_RST;
      s.zero <= orr_pkg::ZERO_RST;
      s.intr_ctl <= orr_pkg::INTR_CTL_RST;
      s.pc <= '0;
      s.sp <= '0;
      s.stack <= '0;
      s.mem <= {MEM_DEPTH{orr_pkg::MEM_RST}};
      s.mem_rdata <= orr_pkg::MEM_RST;
    end else begin
      s <= next_s;
    end
  end

  assign accumulator = s.accumulator;
  assign carry = s.carry;
  assign zero = s.zero;
  assign interrupt_control_reg = s.intr_ctl;
  assign master_interrupt_enable = s.intr_ctl[orr_pkg::MASTER_IE_BIT];
  assign pc = s.pc;
  assign stack_ptr = s.sp;
  assign mem_rdata = s.mem_rdata;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_or_imm_result: assert property (
    instr_valid && instr.op == orr_pkg::ORR_OR_IMM |=> s.accumulator == ($past(s.accumulator) | $past(instr.imm)))
    else $error("or-immediate result wrong");

  a_or_imm_mem_kept: assert property (
    instr_valid && instr.op == orr_pkg::ORR_OR_IMM |=> $stable(s.mem))
    else $error("or-immediate wrote memory");

  a_or_mem_store: assert property (
    instr_valid && instr.op == orr_pkg::ORR_OR_TO_MEMORY_OP |=>
      s.mem[$past(ma)] == ($past(s.accumulator) | $past(mbyte)) && $stable(s.accumulator))
    else $error("or-to-memory result wrong");

  a_ret_pc_pop: assert property (
    instr_valid && instr.op == orr_pkg::ORR_RET |=> s.pc == $past(s.stack[sp_dec]))
    else $error("return did not reload pc");

  a_ret_data_kept: assert property (
    instr_valid && instr.op == orr_pkg::ORR_RET |=> $stable(s.accumulator) && $stable(s.mem))
    else $error("plain return changed data");

  a_ret_imm_acc: assert property (
    instr_valid && instr.op == orr_pkg::ORR_RET_IMM |=>
      s.accumulator == $past(instr.imm) && s.pc == $past(s.stack[sp_dec]))
    else $error("return-immediate wrong");

  a_int_return_ie: assert property (
    instr_valid && instr.op == orr_pkg::ORR_INTERRUPT_RETURN_OP |=>
      master_interrupt_enable && s.pc == $past(s.stack[sp_dec]))
    else $error("interrupt return wrong");

  a_int_return_upper: assert property (
    instr_valid && instr.op == orr_pkg::ORR_INTERRUPT_RETURN_OP |=>
      $stable(s.intr_ctl[7:1]) && $stable(s.accumulator))
    else $error("interrupt return touched other state");

  a_rl_in_place: assert property (
    instr_valid && instr.op == orr_pkg::ORR_ROTATE_LEFT_OP |=>
      s.mem[$past(ma)] == {$past(mbyte[6:0]), $past(mbyte[7])} && $stable(s.carry))
    else $error("rotate left in place wrong");

  a_rl_accumulator_kept: assert property (
    instr_valid && instr.op == orr_pkg::ORR_ROTATE_LEFT_OP |=> $stable(s.accumulator))
    else $error("rotate left changed accumulator");

  a_rotl_to_accumulator: assert property (
    instr_valid && instr.op == orr_pkg::ORR_ROTATE_LEFT_TO_ACC_OP |=>
      s.accumulator == {$past(mbyte[6:0]), $past(mbyte[7])} && s.mem == $past(s.mem))
    else $error("rotate left to accumulator wrong");

  a_rotl_carry_ring: assert property (
    instr_valid && instr.op == orr_pkg::ORR_ROTATE_LEFT_CARRY_OP |=>
      s.mem[$past(ma)] == {$past(mbyte[6:0]), $past(s.carry)} && s.carry == $past(mbyte[7]))
    else $error("rotate through carry wrong");

  a_rotl_carry_accumulator: assert property (
    instr_valid && instr.op == orr_pkg::ORR_ROTATE_LEFT_CARRY_OP |=> $stable(s.accumulator))
    else $error("rotate through carry changed accumulator");

  a_flags_kept: assert property (
    instr_valid && instr.op != orr_pkg::ORR_ROTATE_LEFT_CARRY_OP |=> $stable(s.carry) && $stable(s.zero))
    else $error("untouched flag changed");

  a_idle_hold: assert property (
    !instr_valid |=> $stable(s.carry) && $stable(s.zero) && $stable(s.accumulator) && $stable(s.pc))
    else $error("state changed without an instruction");

  a_ret_sp_dec: assert property (
    instr_valid && (instr.op == orr_pkg::ORR_RET || instr.op == orr_pkg::ORR_RET_IMM ||
      instr.op == orr_pkg::ORR_INTERRUPT_RETURN_OP) |=> s.sp == $past(sp_dec))
    else $error("stack pointer not decremented");

  a_ret_stack_kept: assert property (
    instr_valid && (instr.op == orr_pkg::ORR_RET || instr.op == orr_pkg::ORR_RET_IMM ||
      instr.op == orr_pkg::ORR_INTERRUPT_RETURN_OP) |=> $stable(s.stack))
    else $error("return disturbed the stack");

  // pushes and pops must pair for nested returns to unwind in order
  a_call_push: assert property (
    instr_valid && instr.op == orr_pkg::ORR_CALL |=>
      s.stack[$past(s.sp)] == $past(s.pc) + 1'b1 && s.sp == $past(s.sp) + 1'b1 && s.pc == $past(call_target))
    else $error("call did not push return address");

endmodule : orr_exec

// ---- tb/orr_exec_bench.sv ----
// self-checking bench for the or/return/rotate execution unit
// assumes default parameters: 11-bit pc, four-entry stack, 64-byte memory
module orr_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, instr_valid, carry, zero, mie;
  orr_pkg::orr_instr_t instr;
  logic [10:0] call_target, pc, epc;
  logic [7:0] accumulator, intr_ctl, mem_rdata;
  logic [1:0] stack_ptr;
  logic [10:0] stk[$];
  int num_errors, num_checks;

  orr_exec uut (
    .mclk(mclk),
    .rst_n(rst_n),
    .instr_valid(instr_valid),
    .instr(instr),
    .call_target(call_target),
    .accumulator(accumulator),
    .carry(carry),
    .zero(zero),
    .interrupt_control_reg(intr_ctl),
    .master_interrupt_enable(mie),
    .pc(pc),
    .stack_ptr(stack_ptr),
    .mem_rdata(mem_rdata)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // reference stack kept as a queue, so pc and depth are judged after every op
  task ex(input orr_pkg::orr_op_t op, input logic [7:0] imm, input logic [7:0] a, input logic [10:0] t = 11'h000);
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr <= '{op: op, imm: imm, addr: a};
    call_target <= t;
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1;
    if (op == orr_pkg::ORR_CALL) begin
      stk.push_back(epc + 11'h001);
      epc = t;
    end else if (op >= orr_pkg::ORR_RET && op <= orr_pkg::ORR_INTERRUPT_RETURN_OP) begin
      epc = stk.pop_back();
    end else begin
      epc = epc + 11'h001;
    end
    chk("pc", 16'(pc), 16'(epc));
    chk("stack_ptr", 16'(stack_ptr), 16'(stk.size()));
  endtask : ex

  // snapshot lags one cycle, so the address is held across a full edge
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    instr.addr <= a;
    @(posedge mclk);
    #1;
    chk("mem_rdata", 16'(mem_rdata), 16'(exp));
  endtask : rd

  task t_or;
    ex(orr_pkg::ORR_OR_IMM, 8'h5A, 8'h00);
    chk("accumulator", 16'(accumulator), 16'h005A);
    ex(orr_pkg::ORR_OR_IMM, 8'h81, 8'h00);
    chk("accumulator", 16'(accumulator), 16'h00DB);
    chk("zero", 16'(zero), 16'h0000);
    ex(orr_pkg::ORR_NOP, 8'hFF, 8'h00);
    chk("accumulator", 16'(accumulator), 16'h00DB);
  endtask : t_or

  task t_orm;
    ex(orr_pkg::ORR_STORE_IMM, 8'h20, 8'h03);
    ex(orr_pkg::ORR_OR_TO_MEMORY_OP, 8'h00, 8'h03);
    chk("accumulator", 16'(accumulator), 16'h00DB);
    rd(8'h03, 8'hFB);
  endtask : t_orm

  task t_rot;
    ex(orr_pkg::ORR_STORE_IMM, 8'h96, 8'h05);
    ex(orr_pkg::ORR_ROTATE_LEFT_OP, 8'h00, 8'h05);
    rd(8'h05, 8'h2D);
    chk("carry", 16'(carry), 16'h0000);
    ex(orr_pkg::ORR_ROTATE_LEFT_TO_ACC_OP, 8'h00, 8'h05);
    chk("accumulator", 16'(accumulator), 16'h005A);
    rd(8'h05, 8'h2D);
    ex(orr_pkg::ORR_STORE_IMM, 8'hC3, 8'h06);
    ex(orr_pkg::ORR_ROTATE_LEFT_CARRY_OP, 8'h00, 8'h06);
    rd(8'h06, 8'h86);
    chk("carry", 16'(carry), 16'h0001);
    ex(orr_pkg::ORR_ROTATE_LEFT_CARRY_OP, 8'h00, 8'h06);
    rd(8'h06, 8'h0D);
    chk("carry", 16'(carry), 16'h0001);
  endtask : t_rot

  task t_ret;
    ex(orr_pkg::ORR_CALL, 8'h00, 8'h00, 11'h100);
    ex(orr_pkg::ORR_CALL, 8'h00, 8'h00, 11'h200);
    ex(orr_pkg::ORR_RET, 8'h00, 8'h00);
    chk("carry", 16'(carry), 16'h0001);
    ex(orr_pkg::ORR_RET_IMM, 8'h3C, 8'h00);
    chk("accumulator", 16'(accumulator), 16'h003C);
    ex(orr_pkg::ORR_CALL, 8'h00, 8'h00, 11'h050);
    ex(orr_pkg::ORR_INTERRUPT_RETURN_OP, 8'h00, 8'h00);
    chk("mie", 16'(mie), 16'h0001);
    chk("interrupt_control_reg", 16'(intr_ctl), 16'h0001);
    // clear after the set, so that the next return has something to restore
    ex(orr_pkg::ORR_CLEAR_MASTER_IE, 8'h00, 8'h00);
    chk("mie", 16'(mie), 16'h0000);
    ex(orr_pkg::ORR_CALL, 8'h00, 8'h00, 11'h060);
    ex(orr_pkg::ORR_INTERRUPT_RETURN_OP, 8'h00, 8'h00);
    chk("mie", 16'(mie), 16'h0001);
    chk("accumulator", 16'(accumulator), 16'h003C);
  endtask : t_ret

  // mid-run reset with accumulator, carry, intr_ctl, mie and pc away from their reset values; zero, stack_ptr and mem_rdata already at theirs
  task t_reset;
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    stk.delete();
    epc = '0;
    #1;
    chk("accumulator", 16'(accumulator), 16'h0000);
    chk("carry", 16'(carry), 16'h0000);
    chk("zero", 16'(zero), 16'h0000);
    chk("interrupt_control_reg", 16'(intr_ctl), 16'h0000);
    chk("mie", 16'(mie), 16'h0000);
    chk("pc", 16'(pc), 16'h0000);
    chk("stack_ptr", 16'(stack_ptr), 16'h0000);
    chk("mem_rdata", 16'(mem_rdata), 16'h0000);
    ex(orr_pkg::ORR_NOP, 8'h00, 8'h00);
    rd(8'h06, 8'h00);
    ex(orr_pkg::ORR_CALL, 8'h00, 8'h00, 11'h120);
    ex(orr_pkg::ORR_RET, 8'h00, 8'h00);
  endtask : t_reset

  task results;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  initial begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr = '0;
    call_target = '0;
    epc = '0;
    num_errors = 0;
    num_checks = 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk("accumulator", 16'(accumulator), 16'h0000);
    chk("interrupt_control_reg", 16'(intr_ctl), 16'h0000);
    chk("pc", 16'(pc), 16'h0000);
    t_or();
    t_orm();
    t_rot();
    t_ret();
    t_reset();
    results();
  end
endmodule : orr_exec_bench
